/* File: mstw_pkg.sv */
// Package for the modem timing and DSP window register bank.
// Assumes a single 200 MHz system clock shared by every user.
package mstw_pkg;

  // Register offsets.
  localparam logic [7:0] OFS_CARRIER_RETURN = 8'h37;
  localparam logic [7:0] OFS_CARRIER_WAIT   = 8'h39;
  localparam logic [7:0] OFS_ANSWER_DELAY   = 8'h3a;
  localparam logic [7:0] OFS_CALLER_GAIN    = 8'h3c;
  localparam logic [7:0] OFS_RESET_CTRL     = 8'h62;
  localparam logic [7:0] OFS_INTRUSION      = 8'h82;
  localparam logic [7:0] OFS_LINE_VOLTAGE   = 8'hdb;
  localparam logic [7:0] OFS_GAIN_SETTING   = 8'hdf;
  localparam logic [7:0] OFS_CONFIG_ONE     = 8'he0;
  localparam logic [7:0] OFS_PIN_IO_ONE     = 8'he1;
  localparam logic [7:0] OFS_PIN_IO_TWO     = 8'he2;
  localparam logic [7:0] OFS_PIN_DIR        = 8'he3;
  localparam logic [7:0] OFS_CONFIG_FIVE    = 8'he4;
  localparam logic [7:0] OFS_WINDOW_LOW     = 8'he5;
  localparam logic [7:0] OFS_WINDOW_HIGH    = 8'he6;
  localparam logic [7:0] OFS_WINDOW_MODE    = 8'he8;
  localparam logic [7:0] OFS_TEST_PATH      = 8'heb;
  localparam logic [7:0] OFS_TIMER_STATUS   = 8'hf8;
  localparam logic [7:0] OFS_TIMER_CONTROL  = 8'hf9;

  // Reset values.
  localparam logic [7:0] RST_CARRIER_RETURN = 8'h20;
  localparam logic [7:0] RST_CARRIER_WAIT   = 8'h3c;
  localparam logic [7:0] RST_ANSWER_DELAY   = 8'h29;
  localparam logic [7:0] RST_CALLER_GAIN    = 8'h01;
  localparam logic [7:0] RST_RESET_CTRL     = 8'h41;
  localparam logic [7:0] RST_INTRUSION      = 8'h08;
  localparam logic [7:0] RST_GAIN_SETTING   = 8'h0c;
  localparam logic [7:0] RST_CONFIG_ONE     = 8'h22;
  localparam logic [7:0] RST_PIN_IO_ONE     = 8'h0e;
  localparam logic [7:0] RST_PIN_IO_TWO     = 8'h00;
  localparam logic [7:0] RST_PIN_DIR        = 8'h00;
  localparam logic [7:0] RST_CONFIG_FIVE    = 8'h00;
  localparam logic [7:0] RST_TEST_PATH      = 8'h00;
  localparam logic [7:0] RST_WINDOW_MODE    = 8'h00;
  localparam logic [7:0] ZERO_BYTE          = 8'h00;

  // Window modes.
  localparam logic [7:0] MODE_ADDR = 8'h00;
  localparam logic [7:0] MODE_DATA = 8'h01;
  localparam logic [7:0] MODE_CTRL = 8'h02;

  // Window data word width and line voltage threshold.
  localparam int          DSP_DATA_W       = 14;
  localparam logic [7:0]  VOLT_THRESHOLD   = 8'h03;

  // Timer control bits.
  localparam int TC_CARRIER_LOST = 0;
  localparam int TC_WAIT_START   = 1;
  localparam int TC_ANSWER_START = 2;

  // Timer status bits.
  localparam int TS_CARRIER_OK   = 0;
  localparam int TS_WAIT_ABORT   = 1;
  localparam int TS_ANSWER_TONE  = 2;
  localparam int TS_WAIT_RUN     = 3;
  localparam int TS_ANSWER_RUN   = 4;

  // Timing: base tick of 5/3 ms, in nanoseconds as numerator over denominator.
  localparam longint TICK_NS_NUM    = 64'd5000000;
  localparam longint TICK_NS_DEN    = 64'd3;
  localparam longint CLK_PERIOD_NS  = 64'd5;
  localparam longint TICK_CYCLES    = TICK_NS_NUM / (TICK_NS_DEN * CLK_PERIOD_NS);
  // One second is 600 ticks; 53.33 ms is 32 ticks.
  localparam int     TICKS_PER_SEC  = 600;
  localparam int     TICKS_PER_ATD  = 32;

  typedef enum logic [1:0] {
    CR_IDLE,
    CR_LOST,
    CR_COUNT
  } mstw_carrier_t;

endpackage

/* File: mstw_interval.sv */
// Programmable interval counter measured in base ticks.
// Assumes tick is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module mstw_interval #(
  parameter int CNT_W = 20
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Control.
  input  wire logic             start,
  input  wire logic             stop,
  input  wire logic             tick,
  input  wire logic [CNT_W-1:0] limit,
  // Status.
  output logic                  running,
  output logic                  done
);

  logic [CNT_W-1:0] count_q;
  logic             run_q;
  logic             done_q;

  if (CNT_W < 2) $error("CNT_W too small");

  // Done is sticky until the next start or stop, so a short limit is never missed.
  always_ff @(posedge clk) begin
    if (rst || stop) begin
      count_q <= '0;
      run_q   <= 1'b0;
      done_q  <= 1'b0;
    end else if (start) begin
      count_q <= '0;
      run_q   <= (limit != '0);
      done_q  <= (limit == '0);
    end else if (run_q && tick) begin
      if (count_q + 1'b1 >= limit) begin
        run_q  <= 1'b0;
        done_q <= 1'b1;
      end
      count_q <= count_q + 1'b1;
    end
  end

  assign running = run_q;
  assign done    = done_q;

endmodule

/* File: mstw_regbank.sv */
// Modem timing register bank with line voltage status and DSP window ports.
// Assumes a same-clock register port master and a DSP core on the same clock.
`timescale 1ns/1ps
// Operation
// R1: Returning carrier recognised only after continuous detection for return count times 5/3 ms.
// R2: Abort the call if no carrier within wait count seconds; count resets 0x3C.
// R3: In answer mode start answer tone after delay count times 53.33 ms off-hook.
// R4: Line voltage reads as signed byte, one volt per bit, sign is polarity.
// R5: Line voltage reads zero whenever its magnitude is below three volts.
// R6: Window mode register selects the meaning of both window byte ports.
// R7: Mode 0x00 writes load DSP address low and high bytes.
// R8: Mode 0x01 writes load the 14-bit DSP data word.
// R9: Mode 0x02 reads status byte at low port, writes two control bytes.
// R10: All interval timing derives from one common 5/3 ms tick.
module mstw_regbank #(
  parameter int TICK_CYCLES = int'(mstw_pkg::TICK_CYCLES)
) (
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        RST,
  // Register port.
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  // Modem line events, asynchronous.
  input  wire logic        CARRIER_IN,
  input  wire logic [7:0]  LINE_VOLT_IN,
  // Modem timing outputs.
  output logic             CARRIER_VALID,
  output logic             CALL_ABORT,
  output logic             ANSWER_TONE_GO,
  // DSP window.
  input  wire logic [7:0]  DSP_STATUS_IN,
  output logic      [15:0] DSP_ADDR,
  output logic      [13:0] DSP_DATA,
  output logic      [7:0]  DSP_CTRL_LOW,
  output logic      [7:0]  DSP_CTRL_HIGH,
  output logic             DSP_DATA_WR
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int LONG_W = 20;

  if (TICK_CYCLES < 1) $error("TICK_CYCLES must be at least one");

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Plain storage registers and the timer control strobe register.
  logic [7:0] carrier_return_time_q;
  logic [7:0] carrier_wait_timeout_q;
  logic [7:0] answer_tone_delay_q;
  logic [7:0] caller_info_gain_map_q;
  logic [7:0] reset_control_map_q;
  logic [7:0] intrusion_settings_map_q;
  logic [7:0] gain_setting_map_q;
  logic [7:0] config_one_map_q;
  logic [7:0] pin_io_map_one_q;
  logic [7:0] pin_io_map_two_q;
  logic [7:0] pin_direction_map_q;
  logic [7:0] config_five_map_q;
  logic [7:0] test_path_map_q;
  logic [7:0] window_mode_select_q;
  logic [7:0] timer_ctrl_q;

  // Register writes.
  always_ff @(posedge CLK) begin
    if (RST) begin
      carrier_return_time_q    <= mstw_pkg::RST_CARRIER_RETURN;
      carrier_wait_timeout_q   <= mstw_pkg::RST_CARRIER_WAIT;
      answer_tone_delay_q      <= mstw_pkg::RST_ANSWER_DELAY;
      caller_info_gain_map_q   <= mstw_pkg::RST_CALLER_GAIN;
      reset_control_map_q      <= mstw_pkg::RST_RESET_CTRL;
      intrusion_settings_map_q <= mstw_pkg::RST_INTRUSION;
      gain_setting_map_q       <= mstw_pkg::RST_GAIN_SETTING;
      config_one_map_q         <= mstw_pkg::RST_CONFIG_ONE;
      pin_io_map_one_q         <= mstw_pkg::RST_PIN_IO_ONE;
      pin_io_map_two_q         <= mstw_pkg::RST_PIN_IO_TWO;
      pin_direction_map_q      <= mstw_pkg::RST_PIN_DIR;
      config_five_map_q        <= mstw_pkg::RST_CONFIG_FIVE;
      test_path_map_q          <= mstw_pkg::RST_TEST_PATH;
      window_mode_select_q     <= mstw_pkg::RST_WINDOW_MODE;
    end else if (WR) begin
      if (hit(ADDR, mstw_pkg::OFS_CARRIER_RETURN)) carrier_return_time_q <= WDATA;
      if (hit(ADDR, mstw_pkg::OFS_CARRIER_WAIT)) carrier_wait_timeout_q <= WDATA;
      if (hit(ADDR, mstw_pkg::OFS_ANSWER_DELAY)) answer_tone_delay_q <= WDATA;
      if (hit(ADDR, mstw_pkg::OFS_CALLER_GAIN)) caller_info_gain_map_q <= WDATA;
      if (hit(ADDR, mstw_pkg::OFS_RESET_CTRL)) reset_control_map_q <= WDATA;
      if (hit(ADDR, mstw_pkg::OFS_INTRUSION)) intrusion_settings_map_q <= WDATA;
      if (hit(ADDR, mstw_pkg::OFS_GAIN_SETTING)) gain_setting_map_q <= WDATA;
      if (hit(ADDR, mstw_pkg::OFS_CONFIG_ONE)) config_one_map_q <= WDATA;
      if (hit(ADDR, mstw_pkg::OFS_PIN_IO_ONE)) pin_io_map_one_q <= WDATA;
      if (hit(ADDR, mstw_pkg::OFS_PIN_IO_TWO)) pin_io_map_two_q <= WDATA;
      if (hit(ADDR, mstw_pkg::OFS_PIN_DIR)) pin_direction_map_q <= WDATA;
      if (hit(ADDR, mstw_pkg::OFS_CONFIG_FIVE)) config_five_map_q <= WDATA;
      if (hit(ADDR, mstw_pkg::OFS_TEST_PATH)) test_path_map_q <= WDATA;
      if (hit(ADDR, mstw_pkg::OFS_WINDOW_MODE)) window_mode_select_q <= WDATA; // R6
    end
  end

  // Timer control is a self-clearing strobe register.
  always_ff @(posedge CLK) begin
    if (RST) begin
      timer_ctrl_q <= mstw_pkg::ZERO_BYTE;
    end else if (WR && hit(ADDR, mstw_pkg::OFS_TIMER_CONTROL)) begin
      timer_ctrl_q <= WDATA;
    end else begin
      timer_ctrl_q <= mstw_pkg::ZERO_BYTE;
    end
  end

  // DSP window writes, meaning chosen by the mode register.
  logic [15:0] dsp_addr_q;
  logic [13:0] dsp_data_q;
  logic [7:0]  dsp_ctrl_low_q;
  logic [7:0]  dsp_ctrl_high_q;
  logic        dsp_data_wr_q;
  logic        win_lo_wr;
  logic        win_hi_wr;

  assign win_lo_wr = WR && hit(ADDR, mstw_pkg::OFS_WINDOW_LOW);
  assign win_hi_wr = WR && hit(ADDR, mstw_pkg::OFS_WINDOW_HIGH);

  always_ff @(posedge CLK) begin
    if (RST) begin
      dsp_addr_q      <= 16'h0000;
      dsp_data_q      <= 14'h0000;
      dsp_ctrl_low_q  <= mstw_pkg::ZERO_BYTE;
      dsp_ctrl_high_q <= mstw_pkg::ZERO_BYTE;
      dsp_data_wr_q   <= 1'b0;
    end else begin
      dsp_data_wr_q <= 1'b0;
      case (window_mode_select_q)
        mstw_pkg::MODE_ADDR: begin
          if (win_lo_wr) dsp_addr_q[7:0] <= WDATA; // R7
          if (win_hi_wr) dsp_addr_q[15:8] <= WDATA; // R7
        end
        mstw_pkg::MODE_DATA: begin
          if (win_lo_wr) dsp_data_q[7:0] <= WDATA; // R8
          // The high byte completes the word, so it marks the word as written.
          if (win_hi_wr) begin
            dsp_data_q[13:8] <= WDATA[5:0]; // R8
            dsp_data_wr_q    <= 1'b1;
          end
        end
        mstw_pkg::MODE_CTRL: begin
          if (win_lo_wr) dsp_ctrl_low_q <= WDATA; // R9
          if (win_hi_wr) dsp_ctrl_high_q <= WDATA; // R9
        end
        default: begin
          dsp_data_wr_q <= 1'b0;
        end
      endcase
    end
  end

  // Synchronisers for the line inputs.
  logic       carrier_meta_q;
  logic       carrier_sync_q;
  logic [7:0] volt_meta_q;
  logic [7:0] volt_sync_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      carrier_meta_q <= 1'b0;
      carrier_sync_q <= 1'b0;
      volt_meta_q    <= mstw_pkg::ZERO_BYTE;
      volt_sync_q    <= mstw_pkg::ZERO_BYTE;
    end else begin
      carrier_meta_q <= CARRIER_IN;
      carrier_sync_q <= carrier_meta_q;
      volt_meta_q    <= LINE_VOLT_IN;
      volt_sync_q    <= volt_meta_q;
    end
  end

  // Line voltage status: signed volts, zero below the threshold magnitude.
  logic [7:0] line_voltage_status_q;
  logic [7:0] volt_mag;

  assign volt_mag = volt_sync_q[7] ? 8'(-volt_sync_q) : volt_sync_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      line_voltage_status_q <= mstw_pkg::ZERO_BYTE;
    end else if (volt_mag < mstw_pkg::VOLT_THRESHOLD) begin
      line_voltage_status_q <= mstw_pkg::ZERO_BYTE; // R5
    end else begin
      line_voltage_status_q <= volt_sync_q; // R4
    end
  end

  // Common 5/3 ms tick; integer cycles lose a third of a cycle per tick.
  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0; // R10
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q     <= 1'b0;
    end
  end

  // Carrier return qualification.
  mstw_pkg::mstw_carrier_t cr_state_q;
  logic [7:0]              cr_count_q;
  logic                    carrier_valid_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      cr_state_q      <= mstw_pkg::CR_IDLE;
      cr_count_q      <= mstw_pkg::ZERO_BYTE;
      carrier_valid_q <= 1'b0;
    end else begin
      case (cr_state_q)
        mstw_pkg::CR_IDLE: begin
          carrier_valid_q <= carrier_sync_q;
          if (timer_ctrl_q[mstw_pkg::TC_CARRIER_LOST] || (carrier_valid_q && !carrier_sync_q)) begin
            carrier_valid_q <= 1'b0;
            cr_state_q      <= mstw_pkg::CR_LOST;
          end
        end
        mstw_pkg::CR_LOST: begin
          cr_count_q <= mstw_pkg::ZERO_BYTE;
          if (carrier_sync_q) cr_state_q <= mstw_pkg::CR_COUNT;
        end
        mstw_pkg::CR_COUNT: begin
          if (!carrier_sync_q) begin
            cr_state_q <= mstw_pkg::CR_LOST; // R1
          end else if (cr_count_q >= carrier_return_time_q) begin
            carrier_valid_q <= 1'b1; // R1
            cr_state_q      <= mstw_pkg::CR_IDLE;
          end else if (tick_q) begin
            cr_count_q <= cr_count_q + 1'b1;
          end
        end
        default: begin
          cr_state_q <= mstw_pkg::CR_IDLE;
        end
      endcase
    end
  end

  // Carrier wait timeout and answer delay intervals.
  logic wait_run;
  logic wait_done;
  logic ans_run;
  logic ans_done;
  logic [LONG_W-1:0] wait_limit;
  logic [LONG_W-1:0] ans_limit;

  assign wait_limit = LONG_W'(carrier_wait_timeout_q * mstw_pkg::TICKS_PER_SEC); // R2
  assign ans_limit  = LONG_W'(answer_tone_delay_q * mstw_pkg::TICKS_PER_ATD); // R3

  mstw_interval #(.CNT_W(LONG_W)) u_wait (
    .clk     (CLK),
    .rst     (RST),
    .start   (timer_ctrl_q[mstw_pkg::TC_WAIT_START]),
    .stop    (carrier_sync_q && wait_run),
    .tick    (tick_q),
    .limit   (wait_limit),
    .running (wait_run),
    .done    (wait_done)
  );

  mstw_interval #(.CNT_W(LONG_W)) u_answer (
    .clk     (CLK),
    .rst     (RST),
    .start   (timer_ctrl_q[mstw_pkg::TC_ANSWER_START]),
    .stop    (1'b0),
    .tick    (tick_q),
    .limit   (ans_limit),
    .running (ans_run),
    .done    (ans_done)
  );

  // Read data, one cycle after the strobe.
  logic [7:0] rdata_q;
  logic [7:0] timer_status;

  always_comb begin
    timer_status = mstw_pkg::ZERO_BYTE;
    timer_status[mstw_pkg::TS_CARRIER_OK]  = carrier_valid_q;
    timer_status[mstw_pkg::TS_WAIT_ABORT]  = wait_done;
    timer_status[mstw_pkg::TS_ANSWER_TONE] = ans_done;
    timer_status[mstw_pkg::TS_WAIT_RUN]    = wait_run;
    timer_status[mstw_pkg::TS_ANSWER_RUN]  = ans_run;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_q <= mstw_pkg::ZERO_BYTE;
    end else if (RD) begin
      case (ADDR)
        mstw_pkg::OFS_CARRIER_RETURN: rdata_q <= carrier_return_time_q;
        mstw_pkg::OFS_CARRIER_WAIT:   rdata_q <= carrier_wait_timeout_q;
        mstw_pkg::OFS_ANSWER_DELAY:   rdata_q <= answer_tone_delay_q;
        mstw_pkg::OFS_CALLER_GAIN:    rdata_q <= caller_info_gain_map_q;
        mstw_pkg::OFS_RESET_CTRL:     rdata_q <= reset_control_map_q;
        mstw_pkg::OFS_INTRUSION:      rdata_q <= intrusion_settings_map_q;
        mstw_pkg::OFS_LINE_VOLTAGE:   rdata_q <= line_voltage_status_q; // R4
        mstw_pkg::OFS_GAIN_SETTING:   rdata_q <= gain_setting_map_q;
        mstw_pkg::OFS_CONFIG_ONE:     rdata_q <= config_one_map_q;
        mstw_pkg::OFS_PIN_IO_ONE:     rdata_q <= pin_io_map_one_q;
        mstw_pkg::OFS_PIN_IO_TWO:     rdata_q <= pin_io_map_two_q;
        mstw_pkg::OFS_PIN_DIR:        rdata_q <= pin_direction_map_q;
        mstw_pkg::OFS_CONFIG_FIVE:    rdata_q <= config_five_map_q;
        mstw_pkg::OFS_WINDOW_LOW: begin
          // Only the control mode defines a read here; other modes read zero.
          if (window_mode_select_q == mstw_pkg::MODE_CTRL) begin
            rdata_q <= DSP_STATUS_IN; // R9
          end else begin
            rdata_q <= mstw_pkg::ZERO_BYTE;
          end
        end
        mstw_pkg::OFS_WINDOW_MODE:    rdata_q <= window_mode_select_q;
        mstw_pkg::OFS_TEST_PATH:      rdata_q <= test_path_map_q;
        mstw_pkg::OFS_TIMER_STATUS:   rdata_q <= timer_status;
        default:                      rdata_q <= mstw_pkg::ZERO_BYTE;
      endcase
    end else begin
      rdata_q <= mstw_pkg::ZERO_BYTE;
    end
  end

  assign RDATA          = rdata_q;
  assign CARRIER_VALID  = carrier_valid_q;
  assign CALL_ABORT     = wait_done; // R2
  assign ANSWER_TONE_GO = ans_done; // R3
  assign DSP_ADDR       = dsp_addr_q;
  assign DSP_DATA       = dsp_data_q;
  assign DSP_CTRL_LOW   = dsp_ctrl_low_q;
  assign DSP_CTRL_HIGH  = dsp_ctrl_high_q;
  assign DSP_DATA_WR    = dsp_data_wr_q;

endmodule

/* File: mstw_regbank_chk.sv */
// Checker for the modem timing and DSP window register bank.
// Assumes it is bound to mstw_regbank and sees only that module's ports.
`timescale 1ns/1ps
module mstw_regbank_chk #(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset.
  input wire logic        CLK,
  input wire logic        RST,
  // Register port.
  input wire logic [7:0]  ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  // Line events and timing outputs.
  input wire logic        CARRIER_IN,
  input wire logic [7:0]  LINE_VOLT_IN,
  input wire logic        CARRIER_VALID,
  input wire logic        CALL_ABORT,
  input wire logic        ANSWER_TONE_GO,
  // DSP window.
  input wire logic [7:0]  DSP_STATUS_IN,
  input wire logic [15:0] DSP_ADDR,
  input wire logic [13:0] DSP_DATA,
  input wire logic [7:0]  DSP_CTRL_LOW,
  input wire logic [7:0]  DSP_CTRL_HIGH,
  input wire logic        DSP_DATA_WR
);
  logic [7:0] mode_q;
  logic [7:0] lv_q;
  logic [2:0] lv_age_q;
  logic [7:0] lv_exp;
  logic       w_lo;
  logic       w_hi;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // The mode is shadowed here so every window check knows which map is live.
  always_ff @(posedge CLK) begin
    if (RST) mode_q <= mstw_pkg::RST_WINDOW_MODE;
    else if (WR && ADDR == mstw_pkg::OFS_WINDOW_MODE) mode_q <= WDATA;
  end

  // The voltage is only judged once it has held still past the synchroniser.
  always_ff @(posedge CLK) begin
    lv_q <= LINE_VOLT_IN;
    if (RST || LINE_VOLT_IN != lv_q) lv_age_q <= 3'd0;
    else if (lv_age_q != 3'd7) lv_age_q <= lv_age_q + 3'd1;
  end

  always_comb begin
    lv_exp = ($signed(lv_q) > -8'sd3 && $signed(lv_q) < 8'sd3) ? 8'h00 : lv_q;
    w_lo = WR && ADDR == mstw_pkg::OFS_WINDOW_LOW;
    w_hi = WR && ADDR == mstw_pkg::OFS_WINDOW_HIGH;
  end

  addr_low_load_a: assert property (w_lo && mode_q == mstw_pkg::MODE_ADDR
    |=> DSP_ADDR[7:0] == $past(WDATA)) else $error("address low byte not loaded");
  addr_high_load_a: assert property (w_hi && mode_q == mstw_pkg::MODE_ADDR
    |=> DSP_ADDR[15:8] == $past(WDATA)) else $error("address high byte not loaded");
  data_low_load_a: assert property (w_lo && mode_q == mstw_pkg::MODE_DATA
    |=> DSP_DATA[7:0] == $past(WDATA)) else $error("data low byte not loaded");
  data_high_pulse_a: assert property (w_hi && mode_q == mstw_pkg::MODE_DATA
    |=> DSP_DATA_WR && DSP_DATA[13:8] == $past(WDATA[5:0])) else $error("data word not sent");
  data_pulse_cause_a: assert property (DSP_DATA_WR
    |-> $past(w_hi && mode_q == mstw_pkg::MODE_DATA)) else $error("stray data pulse");
  ctrl_low_load_a: assert property (w_lo && mode_q == mstw_pkg::MODE_CTRL
    |=> DSP_CTRL_LOW == $past(WDATA)) else $error("control low byte not loaded");
  ctrl_high_load_a: assert property (w_hi && mode_q == mstw_pkg::MODE_CTRL
    |=> DSP_CTRL_HIGH == $past(WDATA)) else $error("control high byte not loaded");
  status_read_a: assert property (RD && ADDR == mstw_pkg::OFS_WINDOW_LOW
    && mode_q == mstw_pkg::MODE_CTRL |=> RDATA == $past(DSP_STATUS_IN)) else $error("bad status");
  window_read_zero_a: assert property (RD && ADDR == mstw_pkg::OFS_WINDOW_LOW
    && mode_q != mstw_pkg::MODE_CTRL |=> RDATA == 8'h00) else $error("window read not zero");
  bad_mode_ignored_a: assert property ((w_lo || w_hi) && mode_q > 8'h02
    |=> $stable(DSP_ADDR) && $stable(DSP_DATA) && $stable(DSP_CTRL_LOW) && !DSP_DATA_WR
    && $stable(DSP_CTRL_HIGH)) else $error("window write in unknown mode acted");
  line_volt_read_a: assert property (RD && ADDR == mstw_pkg::OFS_LINE_VOLTAGE
    && lv_age_q >= 3'd4 |=> RDATA == $past(lv_exp)) else $error("line voltage wrong");

  cover property (RD && ADDR == mstw_pkg::OFS_WINDOW_LOW && mode_q == mstw_pkg::MODE_CTRL);
  cover property (DSP_DATA_WR);
  cover property ($rose(CALL_ABORT));
endmodule

bind mstw_regbank mstw_regbank_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .CARRIER_IN(CARRIER_IN), .LINE_VOLT_IN(LINE_VOLT_IN), .CARRIER_VALID(CARRIER_VALID),
  .CALL_ABORT(CALL_ABORT), .ANSWER_TONE_GO(ANSWER_TONE_GO), .DSP_STATUS_IN(DSP_STATUS_IN),
  .DSP_ADDR(DSP_ADDR), .DSP_DATA(DSP_DATA), .DSP_CTRL_LOW(DSP_CTRL_LOW),
  .DSP_CTRL_HIGH(DSP_CTRL_HIGH), .DSP_DATA_WR(DSP_DATA_WR));

/* File: tb_top.sv */
// Self-checking bench for the modem timing and DSP window register bank.
// Assumes the tick is shortened to a few cycles so every interval fits the run.
`timescale 1ns/1ps
module tb_top;
  localparam int TK = 4;
  logic        CLK, RST, WR, RD, CARRIER_IN, CARRIER_VALID, CALL_ABORT;
  logic        ANSWER_TONE_GO, DSP_DATA_WR;
  logic [7:0]  ADDR, WDATA, RDATA, LINE_VOLT_IN, DSP_STATUS_IN, DSP_CTRL_LOW, DSP_CTRL_HIGH;
  logic [7:0]  v;
  logic [15:0] DSP_ADDR;
  logic [13:0] DSP_DATA;
  int          n_mismatch, checked, n;
  logic [7:0]  rs_ofs [15] = '{8'h37, 8'h39, 8'h3a, 8'h3c, 8'h62, 8'h82, 8'hdf, 8'he0,
                               8'he1, 8'he2, 8'he3, 8'he4, 8'he8, 8'heb, 8'h00};
  logic [7:0]  rs_val [15] = '{8'h20, 8'h3c, 8'h29, 8'h01, 8'h41, 8'h08, 8'h0c, 8'h22,
                               8'h0e, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  lv_in [7] = '{8'h05, 8'h02, 8'hfe, 8'hfd, 8'h03, 8'h80, 8'hff};
  logic [7:0]  lv_ex [7] = '{8'h05, 8'h00, 8'h00, 8'hfd, 8'h03, 8'h80, 8'h00};

  mstw_regbank #(.TICK_CYCLES(TK)) dut_u (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .CARRIER_IN(CARRIER_IN), .LINE_VOLT_IN(LINE_VOLT_IN), .CARRIER_VALID(CARRIER_VALID),
    .CALL_ABORT(CALL_ABORT), .ANSWER_TONE_GO(ANSWER_TONE_GO), .DSP_STATUS_IN(DSP_STATUS_IN),
    .DSP_ADDR(DSP_ADDR), .DSP_DATA(DSP_DATA), .DSP_CTRL_LOW(DSP_CTRL_LOW),
    .DSP_CTRL_HIGH(DSP_CTRL_HIGH), .DSP_DATA_WR(DSP_DATA_WR));

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so it is taken just after that edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 q = RDATA;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] q;
    rd(a, q);
    chk(what, {8'h00, q}, {8'h00, exp});
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return CARRIER_VALID;
      1: return CALL_ABORT;
      default: return ANSWER_TONE_GO;
    endcase
  endfunction

  // Counts cycles until the chosen output rises, giving up after maxc.
  // Outputs are looked at on the falling edge, where they have settled.
  task automatic meas(input int sel, input int maxc, output int cnt);
    cnt = 0;
    @(negedge CLK);
    while (cnt < maxc && pick(sel) !== 1'b1) begin
      @(negedge CLK);
      cnt++;
    end
    @(posedge CLK);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    {RST, WR, RD, CARRIER_IN} = 4'b1000;
    {ADDR, WDATA, LINE_VOLT_IN, DSP_STATUS_IN} = 32'h0;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    for (int i = 0; i < 15; i++) rdc(rs_ofs[i], rs_val[i], "reset value");
    for (int i = 0; i < 6; i++) begin
      wr(rs_ofs[i % 3], (i < 3) ? 8'ha5 : 8'h5a);
      rdc(rs_ofs[i % 3], (i < 3) ? 8'ha5 : 8'h5a, "timing count");
    end
    wr(8'hdb, 8'hff);
    wr(8'h10, 8'hff);
    rdc(8'hdb, 8'h00, "line voltage write ignored");
    rdc(8'h10, 8'h00, "unmapped read");
    $display("register test done");
    for (int i = 0; i < 7; i++) begin
      @(posedge CLK);
      LINE_VOLT_IN <= lv_in[i];
      repeat (5) @(posedge CLK);
      rdc(8'hdb, lv_ex[i], "line voltage");
    end
    $display("line voltage test done");
    wr(8'he8, 8'h00);
    wr(8'he5, 8'h34);
    wr(8'he6, 8'h12);
    #1 chk("dsp address", DSP_ADDR, 16'h1234);
    rdc(8'he5, 8'h00, "low port read in address mode");
    rdc(8'he6, 8'h00, "high port read");
    wr(8'he8, 8'h01);
    wr(8'he5, 8'hcd);
    #1 chk("no pulse on low byte", {15'h0, DSP_DATA_WR}, 16'h0000);
    wr(8'he6, 8'hff);
    #1 chk("data pulse", {15'h0, DSP_DATA_WR}, 16'h0001);
    chk("dsp data", {2'b00, DSP_DATA}, 16'h3fcd);
    chk("address kept in data mode", DSP_ADDR, 16'h1234);
    @(posedge CLK);
    #1 chk("data pulse ends", {15'h0, DSP_DATA_WR}, 16'h0000);
    rdc(8'he8, 8'h01, "window mode");
    wr(8'he8, 8'h02);
    DSP_STATUS_IN <= 8'h5a;
    rdc(8'he5, 8'h5a, "dsp status");
    wr(8'he5, 8'ha5);
    wr(8'he6, 8'h3c);
    #1 chk("control bytes", {DSP_CTRL_HIGH, DSP_CTRL_LOW}, 16'h3ca5);
    chk("data kept in control mode", {2'b00, DSP_DATA}, 16'h3fcd);
    wr(8'he8, 8'h03);
    wr(8'he5, 8'h11);
    wr(8'he6, 8'h22);
    #1 chk("control kept in unknown mode", {DSP_CTRL_HIGH, DSP_CTRL_LOW}, 16'h3ca5);
    chk("address kept in unknown mode", DSP_ADDR, 16'h1234);
    $display("window test done");
    // Short counts keep the second-based wait inside the run.
    wr(8'h37, 8'h02);
    wr(8'h39, 8'h01);
    wr(8'h3a, 8'h01);
    wr(mstw_pkg::OFS_TIMER_CONTROL, 8'h04);
    rd(mstw_pkg::OFS_TIMER_STATUS, v);
    chk("answer running", {15'h0, v[4]}, 16'h0001);
    meas(2, 300, n);
    chk("answer delay span", 16'(n >= 31 * TK - 8 && n <= 33 * TK + 4), 16'h0001);
    wr(mstw_pkg::OFS_TIMER_CONTROL, 8'h02);
    meas(1, 2700, n);
    chk("carrier wait span", 16'(n >= 599 * TK && n <= 601 * TK + 4), 16'h0001);
    wr(mstw_pkg::OFS_TIMER_CONTROL, 8'h02);
    repeat (100) @(posedge CLK);
    CARRIER_IN <= 1'b1;
    meas(1, 2600, n);
    chk("carrier stops abort", n[15:0], 16'd2600);
    $display("timer test done");
    CARRIER_IN <= 1'b0;
    repeat (10) @(posedge CLK);
    chk("carrier lost", {15'h0, CARRIER_VALID}, 16'h0000);
    CARRIER_IN <= 1'b1;
    repeat (3) @(posedge CLK);
    CARRIER_IN <= 1'b0;
    repeat (12) @(posedge CLK);
    chk("short carrier ignored", {15'h0, CARRIER_VALID}, 16'h0000);
    CARRIER_IN <= 1'b1;
    meas(0, 40, n);
    chk("carrier return span", 16'(n >= TK && n <= 3 * TK + 4), 16'h0001);
    wr(mstw_pkg::OFS_TIMER_CONTROL, 8'h01);
    @(posedge CLK);
    #1 chk("forced carrier loss", {15'h0, CARRIER_VALID}, 16'h0000);
    $display("carrier test done");
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
